// ==== hw/twc_regs.sv ====
// configuration register bank and host interrupt logic
//
// Added by the designer: register access over Avalon-MM.
`default_nettype none
// Operation
// [R1] threshold bit picks i2c or smbus levels
// [R2] client stretches scl four or eight cycles
// [R3] hold field picks off, short, 300, 500 ns
// [R4] fast plus bit selects 1 MHz operation
// [R5] dual fields configure client only when enabled
// [R6] dual enable bit turns on dual mode
// [R7] debug run bit decides halting during break
// [R8] read irq needs flag and enable
// [R9] write irq needs flag and enable
// [R10] host config a field layout
// [R11] second match mask and enable layout
// [R12] nonzero timeout enables idle supervisor
// [R13] read and write done set flags
// [R14] host enable bit enables host engine
// [R15] unused bits read zero, ignore writes
module twc_regs
    import twc_pkg::*;
#(
    parameter int unsigned TMO_200_CYCLES = TMO_200_CYC
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [6:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cpu_halted,
    input  wire logic        global_irq_enable,
    input  wire logic        host_byte_read_done,
    input  wire logic        host_byte_write_done,
    input  wire logic        scl_in,
    output twc_timing_t      host_timing,
    output twc_timing_t      client_timing,
    output logic             host_enable,
    output logic             quick_command_enable,
    output logic             auto_ack_enable,
    output logic             dual_mode,
    output logic             engine_run,
    output logic             bus_force_idle,
    output logic [6:0]       second_match_mask,
    output logic             second_match_enable,
    output logic             host_irq
);
    logic [7:0] shared_r, dual_r, dbg_r, hosta_r, match_r;
    logic [7:0] other_r [IDX_HOST_CMD_B:IDX_CLIENT_BUF];
    logic [7:0] stat_r, mask_r;
    logic       ack_r;
    logic [4:0] idx;
    logic       wr_hit, rd_hit;
    logic [1:0] scl_sync_r;
    logic       scl_prev_r;
    logic [31:0] idle_cnt_r;
    logic [31:0] tmo_limit;
    logic [7:0] rdat;

    // one wait state: answer in the cycle after the request appears
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign idx    = avs_address[6:2];
    assign wr_hit = avs_write & ack_r & avs_byteenable[0];
    assign rd_hit = avs_read & ack_r;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    function automatic logic [7:0] merge(input logic [7:0] msk);
        merge = avs_writedata[7:0] & msk;
    endfunction

    always_ff @(posedge clock) begin
        if (!nrst) begin
            shared_r <= RST_REG;
            dual_r   <= RST_REG;
            dbg_r    <= RST_REG;
            hosta_r  <= RST_REG;
            match_r  <= RST_REG;
            mask_r   <= RST_REG;
        end else if (wr_hit) begin
            unique case (idx)
                5'(IDX_BUS_SHARED):   shared_r <= merge(MSK_BUS_SHARED); // [R15]
                5'(IDX_CLIENT_DUAL):  dual_r <= merge(MSK_CLIENT_DUAL); // [R6]
                5'(IDX_DEBUG_HALT):   dbg_r <= merge(MSK_DEBUG_HALT);
                5'(IDX_HOST_CFG_A):   hosta_r <= merge(MSK_HOST_CFG_A); // [R10]
                5'(IDX_SECOND_MATCH): match_r <= avs_writedata[7:0]; // [R11]
                IDX_IRQ_MASK:         mask_r <= merge(MSK_IRQ);
                default: ;
            endcase
        end
    end

    // plain storage for engine registers kept elsewhere
    genvar g;
    generate
        for (g = IDX_HOST_CMD_B; g <= IDX_CLIENT_BUF; g++) begin : g_store
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    other_r[g] <= RST_REG;
                end else if (wr_hit && idx == 5'(g)) begin
                    other_r[g] <= avs_writedata[7:0];
                end
            end
        end
    endgenerate

    // break halt blocks events unless run-while-halted is set
    assign engine_run = ~cpu_halted | dbg_r[0]; // [R7]

    // sticky flags; set wins over write-one clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stat_r <= RST_REG;
        end else begin
            stat_r <= ((stat_r & ~((wr_hit && idx == 5'(IDX_IRQ_STATUS))
                        ? merge(MSK_IRQ) : 8'h00))
                      | {6'h00, engine_run & host_byte_write_done,
                         engine_run & host_byte_read_done}); // [R13]
        end
    end

    assign host_irq = global_irq_enable &
        (((stat_r[0] & hosta_r[7]) | (stat_r[1] & hosta_r[6]))
         | |(stat_r & mask_r)); // [R8] [R9]

    always_comb begin
        rdat = 8'h00;
        unique case (idx)
            5'(IDX_BUS_SHARED):   rdat = shared_r;
            5'(IDX_CLIENT_DUAL):  rdat = dual_r;
            5'(IDX_DEBUG_HALT):   rdat = dbg_r;
            5'(IDX_HOST_CFG_A):   rdat = hosta_r;
            5'(IDX_SECOND_MATCH): rdat = match_r;
            5'(IDX_IRQ_STATUS):   rdat = stat_r;
            IDX_IRQ_MASK:         rdat = mask_r;
            default: begin
                if (idx >= 5'(IDX_HOST_CMD_B) && idx <= 5'(IDX_CLIENT_BUF)) begin
                    rdat = other_r[idx[3:0]];
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= {24'h00_0000, rdat};
        end
    end

    function automatic twc_timing_t decode(input twc_line_cfg_t c);
        twc_timing_t t;
        t.smbus_levels = c.input_threshold_select; // [R1]
        t.setup_cycles = c.data_setup_stretch ? 4'(SETUP_LONG)
                                              : 4'(SETUP_SHORT); // [R2]
        unique case (c.data_hold_select) // [R3]
            HOLD_OFF:   t.hold_cycles = 4'h0;
            HOLD_SHORT: t.hold_cycles = 4'(HOLD_SHORT_CYC);
            HOLD_300:   t.hold_cycles = 4'(HOLD_300_CYC);
            HOLD_500:   t.hold_cycles = 4'(HOLD_500_CYC);
        endcase
        t.fast_plus = c.one_megahertz_select; // [R4]
        return t;
    endfunction

    twc_line_cfg_t shared_cfg, client_cfg;
    assign shared_cfg = {shared_r[6], shared_r[4], shared_r[3:2],
                         shared_r[1]};
    assign dual_mode  = dual_r[0]; // [R6]
    // client setup stretch always comes from the shared register
    assign client_cfg = dual_mode
        ? {dual_r[6], shared_r[4], dual_r[3:2], dual_r[1]}
        : shared_cfg; // [R5]

    always_ff @(posedge clock) begin
        if (!nrst) begin
            host_timing   <= '0;
            client_timing <= '0;
        end else begin
            host_timing   <= decode(shared_cfg);
            client_timing <= decode(client_cfg);
        end
    end

    assign host_enable          = hosta_r[0]; // [R14]
    assign auto_ack_enable      = hosta_r[1];
    assign quick_command_enable = hosta_r[4];
    assign second_match_mask    = match_r[7:1];
    assign second_match_enable  = match_r[0];

    // inactivity supervisor on synchronised scl edges
    always_ff @(posedge clock) begin
        if (!nrst) begin
            scl_sync_r <= 2'b11;
            scl_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            scl_prev_r <= scl_sync_r[1];
        end
    end

    always_comb begin
        unique case (twc_tmo_t'(hosta_r[3:2])) // [R12]
            TMO_OFF: tmo_limit = 32'h0000_0000;
            TMO_50:  tmo_limit = 32'(TMO_50_CYC);
            TMO_100: tmo_limit = 32'(TMO_100_CYC);
            TMO_200: tmo_limit = 32'(TMO_200_CYCLES);
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            idle_cnt_r     <= 32'h0000_0000;
            bus_force_idle <= 1'b0;
        end else if (tmo_limit == 32'h0 || scl_prev_r != scl_sync_r[1]
                     || !engine_run) begin
            idle_cnt_r     <= 32'h0000_0000;
            bus_force_idle <= 1'b0;
        end else if (idle_cnt_r >= tmo_limit - 32'h1) begin
            bus_force_idle <= 1'b1; // [R12]
        end else begin
            idle_cnt_r <= idle_cnt_r + 32'h1;
        end
    end

    AST_RD_IRQ: assert property (@(posedge clock) disable iff (!nrst)
        (global_irq_enable && stat_r[0] && hosta_r[7]) |-> host_irq) // [R8]
        else $error("read irq missing");
    AST_WR_IRQ: assert property (@(posedge clock) disable iff (!nrst)
        (global_irq_enable && stat_r[1] && hosta_r[6]) |-> host_irq) // [R9]
        else $error("write irq missing");
    AST_NO_IRQ: assert property (@(posedge clock) disable iff (!nrst)
        !global_irq_enable |-> !host_irq) // [R8]
        else $error("irq without global enable");
    AST_RD_SET: assert property (@(posedge clock) disable iff (!nrst)
        (host_byte_read_done && engine_run) |=> stat_r[0]) // [R13]
        else $error("read flag not set");
    AST_WR_SET: assert property (@(posedge clock) disable iff (!nrst)
        (host_byte_write_done && engine_run) |=> stat_r[1]) // [R13]
        else $error("write flag not set");
    AST_HALT: assert property (@(posedge clock) disable iff (!nrst)
        (cpu_halted && !dbg_r[0]) |-> !engine_run) // [R7]
        else $error("engine runs in halt");
    AST_RSV: assert property (@(posedge clock) disable iff (!nrst)
        (shared_r[7] | shared_r[5] | shared_r[0] | hosta_r[5]
         | |dbg_r[7:1]) == 1'b0) // [R15]
        else $error("reserved bit set");
    AST_DUAL: assert property (@(posedge clock) disable iff (!nrst)
        !dual_mode |=> client_timing == host_timing) // [R5]
        else $error("dual fields leak");
    AST_SETUP: assert property (@(posedge clock) disable iff (!nrst)
        shared_r[4] |=> host_timing.setup_cycles == 4'(SETUP_LONG)) // [R2]
        else $error("setup stretch wrong");
    AST_WAIT: assert property (@(posedge clock) disable iff (!nrst)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");

    COV_RD_IRQ: cover property (@(posedge clock) host_irq && stat_r[0]);
    COV_DUAL:   cover property (@(posedge clock) dual_mode && dual_r[1]);
    COV_IDLE:   cover property (@(posedge clock) bus_force_idle);
endmodule
`default_nettype wire

// ==== hw/twc_pkg.sv ====
// package for the two-wire configuration register bank
`default_nettype none
package twc_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_BUS_SHARED   = 4'h0;
    localparam logic [3:0] IDX_CLIENT_DUAL  = 4'h1;
    localparam logic [3:0] IDX_DEBUG_HALT   = 4'h2;
    localparam logic [3:0] IDX_HOST_CFG_A   = 4'h3;
    localparam logic [3:0] IDX_HOST_CMD_B   = 4'h4;
    localparam logic [3:0] IDX_HOST_FLAGS   = 4'h5;
    localparam logic [3:0] IDX_HOST_RATE    = 4'h6;
    localparam logic [3:0] IDX_HOST_TADDR   = 4'h7;
    localparam logic [3:0] IDX_HOST_BUF     = 4'h8;
    localparam logic [3:0] IDX_CLIENT_CFG_A = 4'h9;
    localparam logic [3:0] IDX_CLIENT_CMD_B = 4'hA;
    localparam logic [3:0] IDX_CLIENT_FLAGS = 4'hB;
    localparam logic [3:0] IDX_CLIENT_OWN   = 4'hC;
    localparam logic [3:0] IDX_CLIENT_BUF   = 4'hD;
    localparam logic [3:0] IDX_SECOND_MATCH = 4'hE;
    localparam logic [3:0] IDX_IRQ_STATUS   = 4'hF;
    localparam logic [4:0] IDX_IRQ_MASK     = 5'h10;

    // writable bit masks; other bits read zero
    localparam logic [7:0] MSK_BUS_SHARED   = 8'h5E;
    localparam logic [7:0] MSK_CLIENT_DUAL  = 8'h4F;
    localparam logic [7:0] MSK_DEBUG_HALT   = 8'h01;
    localparam logic [7:0] MSK_HOST_CFG_A   = 8'hDF;
    localparam logic [7:0] MSK_IRQ          = 8'h03;
    localparam logic [7:0] RST_REG          = 8'h00;

    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SETUP_SHORT = 4;
    localparam int unsigned SETUP_LONG  = 8;
    localparam int unsigned HOLD_300_NS = 300;
    localparam int unsigned HOLD_500_NS = 500;
    localparam int unsigned HOLD_SHORT_CYC = 1;
    // both hold times round down
    localparam int unsigned HOLD_300_CYC = HOLD_300_NS * 25 / 1000;
    localparam int unsigned HOLD_500_CYC = HOLD_500_NS * 25 / 1000;
    localparam int unsigned TMO_50_US  = 50;
    localparam int unsigned TMO_100_US = 100;
    localparam int unsigned TMO_200_US = 200;
    localparam int unsigned TMO_50_CYC  = TMO_50_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TMO_100_CYC = TMO_100_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TMO_200_CYC = TMO_200_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        HOLD_OFF, HOLD_SHORT, HOLD_300, HOLD_500
    } twc_hold_t;

    typedef enum logic [1:0] {
        TMO_OFF, TMO_50, TMO_100, TMO_200
    } twc_tmo_t;

    typedef struct packed {
        logic      input_threshold_select;
        logic      data_setup_stretch;
        twc_hold_t data_hold_select;
        logic      one_megahertz_select;
    } twc_line_cfg_t;

    typedef struct packed {
        logic [3:0] hold_cycles;
        logic [3:0] setup_cycles;
        logic       smbus_levels;
        logic       fast_plus;
    } twc_timing_t;
endpackage
`default_nettype wire

// ==== sim/twc_bus_model.sv ====
// behavioural model of the far bus side, driving the clock line
`default_nettype none
module twc_bus_model (
    output logic scl
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up holds the line high between frames; no free-running clock
    initial scl = 1'b1;
    // odd start offset puts each scl edge 13 ns after a bench clock rising edge
    task automatic frame(input int n);
        #13;
        repeat (n) begin
            #160 scl = 1'b0;
            #160 scl = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_twc_regs.sv ====
// self-checking testbench for the two-wire configuration register bank
`default_nettype none
`define CHK(e, g) chk(32'(e), 32'(g))
module tb_twc_regs import twc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, nrst, avs_read, avs_write, avs_waitrequest;
    logic [6:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        cpu_halted, gie, rdd, wrd, scl_in;
    twc_timing_t host_timing, client_timing;
    logic        host_enable, qc_en, aa_en, dual_mode, engine_run;
    logic        force_idle, sm_en, host_irq;
    logic [6:0]  sm_mask;
    logic [7:0]  v, d;
    logic [31:0] exp_q[$];
    int          mismatches, checks_done, i, seed;

    twc_regs #(.TMO_200_CYCLES(20)) DUT (
        .clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_halted(cpu_halted), .global_irq_enable(gie),
        .host_byte_read_done(rdd), .host_byte_write_done(wrd),
        .scl_in(scl_in), .host_timing(host_timing),
        .client_timing(client_timing), .host_enable(host_enable),
        .quick_command_enable(qc_en), .auto_ack_enable(aa_en),
        .dual_mode(dual_mode), .engine_run(engine_run),
        .bus_force_idle(force_idle), .second_match_mask(sm_mask),
        .second_match_enable(sm_en), .host_irq(host_irq));
    twc_bus_model bus_m (.scl(scl_in));

    always #20 clock = ~clock;

    task automatic final_report();
        if (exp_q.size() != 0) mismatches++;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // entered just after a rising edge; waitrequest is taken at rising edges,
    // before the design's flops move, so the master sees the settled value
    task automatic bus(input logic wr, input logic [4:0] idx,
                       input logic [7:0] dat);
        int n;
        avs_address   <= {idx, 2'b00};
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, dat};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            final_report();
        end
        // release right after the accepting edge; registered outputs
        // follow one edge later, so two edges pass before the next step
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic rd(input logic [4:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] dat);
        bus(1'b1, idx, dat);
    endtask

    task automatic pulse(input logic r);
        rdd <= r;
        wrd <= !r;
        @(posedge clock);
        rdd <= 1'b0;
        wrd <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    function automatic twc_timing_t tm(input logic [7:0] c, input logic [7:0] s);
        twc_timing_t t;
        t.hold_cycles = c[3] ? (c[2] ? 4'(HOLD_500_CYC) : 4'(HOLD_300_CYC))
                             : (c[2] ? 4'(HOLD_SHORT_CYC) : 4'h0);
        t.setup_cycles = s[4] ? 4'(SETUP_LONG) : 4'(SETUP_SHORT);
        t.smbus_levels = c[6];
        t.fast_plus = c[1];
        return t;
    endfunction

    // read data stand at the rising edge where waitrequest is seen low
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) `CHK(32'h0, 32'hFFFF_FFFF);
            else `CHK(exp_q.pop_front(), avs_readdata);
        end
    end

    initial begin
        repeat (50000) @(posedge clock);
        mismatches++;
        final_report();
    end

    initial begin
        seed = 92;
        clock = 1'b0;
        nrst = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {cpu_halted, gie, rdd, wrd} = 4'h0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 18; i++) rd(5'(i), 8'h00);
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr(5'h0, v);
            rd(5'h0, v & MSK_BUS_SHARED);
            `CHK(tm(v, v), host_timing);
            `CHK(tm(v, v), client_timing);
        end
        d = 8'($random(seed)) | 8'h01;
        wr(5'h1, d);
        rd(5'h1, d & MSK_CLIENT_DUAL);
        `CHK(1'b1, dual_mode);
        `CHK(tm(d, v), client_timing);
        `CHK(tm(v, v), host_timing);
        wr(5'h1, 8'h00);
        `CHK(tm(v, v), client_timing);
        wr(5'h11, 8'hFF);
        rd(5'h11, 8'h00);
        wr(5'h3, 8'hFF);
        rd(5'h3, MSK_HOST_CFG_A);
        `CHK(3'b111, {host_enable, qc_en, aa_en});
        wr(5'h3, 8'h01);
        `CHK(3'b100, {host_enable, qc_en, aa_en});
        v = 8'($random(seed));
        wr(5'hE, v);
        rd(5'hE, v);
        `CHK(v, {sm_mask, sm_en});
        for (i = 0; i < 4; i++) begin
            wr(5'h2, 8'(i & 1));
            cpu_halted <= i[1];
            repeat (2) @(posedge clock);
            `CHK(!i[1] | i[0], engine_run);
        end
        cpu_halted <= 1'b1;
        wr(5'h2, 8'h00);
        pulse(1'b1);
        rd(5'hF, 8'h00);
        cpu_halted <= 1'b0;
        gie <= 1'b1;
        wr(5'h3, 8'hC0);
        pulse(1'b1);
        `CHK(1'b1, host_irq);
        rd(5'hF, 8'h01);
        gie <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(1'b0, host_irq);
        gie <= 1'b1;
        wr(5'hF, 8'h01);
        `CHK(1'b0, host_irq);
        wr(5'h3, 8'h00);
        wr(5'h10, 8'h02);
        rd(5'h10, 8'h02);
        pulse(1'b0);
        `CHK(1'b1, host_irq);
        wr(5'h10, 8'h00);
        `CHK(1'b0, host_irq);
        wr(5'h3, 8'h40);
        `CHK(1'b1, host_irq);
        wr(5'hF, 8'h02);
        `CHK(1'b0, host_irq);
        wr(5'h3, 8'h00);
        bus_m.frame(9);
        repeat (40) @(posedge clock);
        `CHK(1'b0, force_idle);
        wr(5'h3, 8'h0C);
        bus_m.frame(9);
        repeat (40) @(posedge clock);
        `CHK(1'b1, force_idle);
        final_report();
    end
endmodule
`default_nettype wire
